// File: design/acr_top.sv
// output coding, range flag pipeline and three-state output stage
`timescale 1ns/100ps
module acr_top (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [13:0] sample_raw,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  input  wire logic        format_select,
  input  wire logic        output_drive_enable_n,
  output logic [11:0]      data_out,
  output logic             data_oe,
  output logic             range_exceeded_flag,
  output logic             out_valid,
  input  wire logic        out_ready
);
  localparam int WW = $bits(acr_pkg::acr_word_t);

  typedef struct packed {
    acr_pkg::acr_word_t [acr_pkg::PIPE_LAT-1:0] pipe;
    logic [acr_pkg::PIPE_LAT-1:0]                pv;
    logic [11:0]                                 dout;
    logic                                        flag;
    logic                                        oe;
    logic                                        ov;
  } acr_state_t;

  acr_state_t         s_r;
  acr_state_t         s_nxt;
  logic               fmt_s;
  logic               oen_s;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic [WW-1:0]      fifo_out_data;
  acr_pkg::acr_word_t fifo_word;
  acr_pkg::acr_word_t coded;
  logic               stall;

  // code one signed raw sample into the selected format
  function automatic acr_pkg::acr_word_t code_sample(
    input logic signed [13:0] raw,
    input logic               twos
  );
    acr_pkg::acr_word_t w;
    w = '0;
    if (raw < acr_pkg::RAW_NEG_FS) begin
      w.code                = acr_pkg::CODE_MIN; // [RULE_01]
      w.range_exceeded_flag = 1'b1; // [RULE_03]
    end else if (raw >= acr_pkg::RAW_POS_FS) begin
      w.code                = acr_pkg::CODE_MAX; // [RULE_01]
      w.range_exceeded_flag = 1'b1; // [RULE_03]
    end else begin
      w.code = raw[11:0] ^ acr_pkg::CODE_MID; // [RULE_01]
      w.range_exceeded_flag = 1'b0; // [RULE_05]
    end
    if (twos) begin
      w.code = w.code ^ acr_pkg::MSB_FLIP; // [RULE_02]
    end
    return w;
  endfunction : code_sample

  // strap and enable pins arrive from outside the clock domain
  acr_sync u_fmt_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (format_select),
    .dout    (fmt_s)
  );
  acr_sync u_oen_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (output_drive_enable_n),
    .dout    (oen_s)
  );

  // stall the pipe when the fifo is full and the last pipe stage holds a valid word
  assign stall        = !fifo_in_ready && s_r.pv[acr_pkg::PIPE_LAT-1];
  assign sample_ready = !stall;
  assign coded        = code_sample(sample_raw, fmt_s);

  // word and flag move together through one pipeline register chain
  always_comb begin
    s_nxt = s_r;
    if (!stall) begin
      s_nxt.pipe[0] = coded; // [RULE_10]
      s_nxt.pv[0]   = sample_valid;
      for (int i = 1; i < acr_pkg::PIPE_LAT; i++) begin
        s_nxt.pipe[i] = s_r.pipe[i-1]; // [RULE_04]
        s_nxt.pv[i]   = s_r.pv[i-1]; // [RULE_11]
      end
    end
    // output stage holds last word until a new one is popped
    if (fifo_pop) begin
      s_nxt.dout = fifo_word.code;
      s_nxt.flag = fifo_word.range_exceeded_flag; // [RULE_05]
    end
    s_nxt.ov = fifo_out_valid && (out_ready || !s_r.ov) ? 1'b1 :
               (out_ready ? 1'b0 : s_r.ov);
    s_nxt.oe = !oen_s; // [RULE_07]
  end

  assign fifo_pop  = fifo_out_valid && (out_ready || !s_r.ov);
  assign fifo_word = acr_pkg::acr_word_t'(fifo_out_data);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  acr_fifo #(
    .WIDTH (WW),
    .DEPTH (acr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_data   (s_r.pipe[acr_pkg::PIPE_LAT-1]),
    .in_valid  (s_r.pv[acr_pkg::PIPE_LAT-1]),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  assign data_out            = s_r.dout;
  assign range_exceeded_flag = s_r.flag;
  assign data_oe             = s_r.oe;
  assign out_valid           = s_r.ov;

  // data and flag change only together
  a_flag_with_data: assert property (@(posedge mclk) disable iff (!reset_n)
    $changed(range_exceeded_flag) |-> $past(fifo_pop)) // [RULE_04]
    else $error("flag changed without a data word");
  // flag set forces full scale code
  a_flag_full_scale: assert property (@(posedge mclk) disable iff (!reset_n)
    range_exceeded_flag |-> (data_out == acr_pkg::CODE_MAX ||
      data_out == acr_pkg::CODE_MIN || data_out == acr_pkg::MSB_FLIP ||
      data_out == (acr_pkg::CODE_MAX ^ acr_pkg::MSB_FLIP))) // [RULE_03]
    else $error("range flag with non full scale code");
  // enable follows pin within sync latency
  a_oe_follows: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(oen_s) |-> !data_oe) // [RULE_07]
    else $error("outputs driven while enable is high");
  // flag holds until a new word arrives
  a_flag_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(range_exceeded_flag) && !$past(fifo_pop) |-> range_exceeded_flag)
    // [RULE_05]
    else $error("flag dropped without an in-range word");
  // in-range words keep the midscale mapping
  a_mid_code: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && sample_ready && sample_raw == '0 && !fmt_s
    |=> s_r.pipe[0].code == acr_pkg::CODE_MID) // [RULE_01]
    else $error("zero input not coded to midscale");
  a_twos_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && sample_ready && sample_raw == '0 && fmt_s
    |=> s_r.pipe[0].code == acr_pkg::CODE_MIN) // [RULE_02]
    else $error("zero input not coded to zero");
  a_pipe_latency: assert property (@(posedge mclk) disable iff (!reset_n)
    !stall && $past(!stall) && $past(!stall, 2) && $past(!stall, 3)
    |-> s_r.pv[2] == $past(sample_valid, 3)) // [RULE_11]
    else $error("pipeline latency not fixed");
  a_sample_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) && $past(!stall) |-> s_r.pipe[0] == $past(coded)) // [RULE_10]
    else $error("sample not taken on rising edge");

  c_over: cover property (@(posedge mclk) range_exceeded_flag && data_out[11]);
  c_under: cover property (@(posedge mclk)
    range_exceeded_flag && !data_out[11]);
  c_stall: cover property (@(posedge mclk) stall);
  c_hiz: cover property (@(posedge mclk) !data_oe ##1 data_oe);
endmodule : acr_top

// File: design/acr_pkg.sv
// constants and carrier types for the adc output coding and range flag block
// Overview of operation
// [RULE_01] binary: zeros low, midscale 800, ones high
// [RULE_02] twos complement: 800 low, zero mid, 7FF high
// [RULE_03] flag high when input beyond converter span
// [RULE_04] flag shares data word pipeline latency exactly
// [RULE_05] flag holds until in-range sample emerges
// [RULE_06] far side: flag plus msb gives under/over
// [RULE_07] enable low drives data, high releases drivers
// [RULE_08] far side: enable only for slow isolation
// [RULE_09] board straps format select low or high
// [RULE_10] sample taken on rising clock edge
// [RULE_11] one word and flag per cycle, fixed delay; code delay grows with fifo fill while the far side holds off out_ready
package acr_pkg;
  localparam int          DATA_W     = 12;
  localparam int          RAW_W      = 14;
  localparam int          FIFO_DEPTH = 8;
  localparam int          PIPE_LAT   = 3;
  localparam int          SYNC_LEN   = 3;
  localparam logic [11:0] CODE_MID   = 12'h800;
  localparam logic [11:0] CODE_MAX   = 12'hFFF;
  localparam logic [11:0] CODE_MIN   = 12'h000;
  localparam logic [11:0] MSB_FLIP   = 12'h800;
  // signed input: full scale is -2048 .. +2047, raw is 14 bit signed
  localparam logic signed [13:0] RAW_NEG_FS = 14'sh3800;
  localparam logic signed [13:0] RAW_POS_FS = 14'sh0800;
  localparam logic [1:0]  SYNC_OK    = 2'h3;

  typedef enum logic [0:0] {
    ACR_FMT_BINARY = 1'b0,
    ACR_FMT_TWOS   = 1'b1
  } acr_fmt_t;

  typedef struct packed {
    logic [11:0] code;
    logic        range_exceeded_flag;
  } acr_word_t;
endpackage : acr_pkg

// File: design/acr_sync.sv
// three stage synchroniser with agreement filter for a strap input
`timescale 1ns/100ps
module acr_sync (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0] st;
    logic       q;
  } acr_sync_state_t;
  acr_sync_state_t s_r;
  acr_sync_state_t s_nxt;

  // shift, accept a change only when stages two and three agree
  always_comb begin
    s_nxt    = s_r;
    s_nxt.st = {s_r.st[1:0], din};
    if ({s_r.st[2], s_r.st[1]} == acr_pkg::SYNC_OK) begin
      s_nxt.q = 1'b1;
    end else if ({s_r.st[2], s_r.st[1]} == 2'h0) begin
      s_nxt.q = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign dout = s_r.q;
endmodule : acr_sync

// File: design/acr_fifo.sv
// parameterised valid/ready fifo for the sample stream
`timescale 1ns/100ps
module acr_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } acr_fifo_state_t;
  acr_fifo_state_t  s_r;
  acr_fifo_state_t  s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (s_r.cnt != DEPTH[AW:0]);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = mem[s_r.rp];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (do_wr) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (do_rd) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
    if (do_wr) begin
      mem[s_r.wp] <= in_data;
    end
  end
endmodule : acr_fifo

// File: testbench/acr_capture_model.sv
// downstream capture model: latches words and sorts range condition
`timescale 1ns/100ps
module acr_capture_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [11:0] data_bus,
  input  wire logic        range_exceeded_flag,
  input  wire logic        out_valid,
  input  wire logic        hold_off,
  output logic             out_ready
);
  logic [14:0] got_q[$]; // {class, flag, code}; class 1 flag with msb low, 2 flag with msb high
  logic [1:0]  cls;

  initial out_ready = 1'b0;
  // flag with top bit tells under from over
  assign cls = !range_exceeded_flag ? 2'h0 : data_bus[11] ? 2'h2 : 2'h1;
  // take a word per handshake, stall while held off
  always @(posedge mclk) begin
    if (reset_n && out_valid && out_ready) begin
      got_q.push_back({cls, range_exceeded_flag, data_bus});
    end
    out_ready <= reset_n && !hold_off;
  end
endmodule : acr_capture_model

// File: testbench/testbench.sv
// self-checking bench for output coding, range flag and drive enable
`timescale 1ns/100ps
module testbench;
  logic        mclk, reset_n, sample_valid, sample_ready, format_select;
  logic        output_drive_enable_n, data_oe, range_exceeded_flag;
  logic        out_valid, out_ready, hold_off, seen_refuse;
  logic [13:0] sample_raw;
  logic [11:0] data_out;
  wire  [11:0] data_bus;
  logic [14:0] exp_q[$];
  int          fail_count, n_compared, cycles;

  // released pins float
  assign data_bus = data_oe ? data_out : 12'hZZZ;

  acr_top dut (.mclk(mclk), .reset_n(reset_n), .sample_raw(sample_raw),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .format_select(format_select),
    .output_drive_enable_n(output_drive_enable_n), .data_out(data_out),
    .data_oe(data_oe), .range_exceeded_flag(range_exceeded_flag),
    .out_valid(out_valid), .out_ready(out_ready));

  acr_capture_model partner (.mclk(mclk), .reset_n(reset_n),
    .data_bus(data_bus), .range_exceeded_flag(range_exceeded_flag),
    .out_valid(out_valid), .hold_off(hold_off), .out_ready(out_ready));

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(string what, logic [14:0] seen, logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // expected {class, flag, code} for one raw sample
  function automatic logic [14:0] expect_word(logic signed [13:0] r,
                                              logic twos);
    logic [11:0] c;
    logic        f;
    f = (r < -2048) || (r > 2047);
    c = (r < -2048) ? 12'h000 : (r > 2047) ? 12'hFFF : r[11:0] ^ 12'h800;
    if (twos) c = c ^ 12'h800;
    return {f ? (c[11] ? 2'h2 : 2'h1) : 2'h0, f, c};
  endfunction : expect_word

  // present one sample, hold it until taken
  task automatic send(logic [13:0] raw);
    sample_raw   = raw;
    sample_valid = 1'b1;
    while (!sample_ready) begin
      seen_refuse = 1'b1;
      @(negedge mclk);
    end
    exp_q.push_back(expect_word(raw, format_select));
    @(negedge mclk);
  endtask : send

  // wait for all words, compare in order
  task automatic drain(string what);
    int n;
    sample_valid = 1'b0;
    n = 0;
    while (partner.got_q.size() < exp_q.size() && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(what, 15'(partner.got_q.size()), 15'(exp_q.size()));
    while (exp_q.size() > 0 && partner.got_q.size() > 0) begin
      check(what, partner.got_q.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    partner.got_q.delete();
  endtask : drain

  // boundary codes back to back, flag set and cleared
  task automatic coding_table(logic fmt);
    int vals[8] = '{-3000, -2049, -2048, 0, 5, 2047, 2048, -1};
    format_select = fmt;
    repeat (8) @(negedge mclk);
    foreach (vals[i]) send(14'(vals[i]));
    drain(fmt ? "twos word" : "binary word");
  endtask : coding_table

  // far side stalls for 40 cycles so the pipe refuses, then drains
  task automatic stall_test();
    hold_off    = 1'b1;
    seen_refuse = 1'b0;
    fork
      begin
        repeat (40) @(negedge mclk);
        hold_off = 1'b0;
      end
    join_none
    for (int i = 0; i < 16; i++) send(14'(i * 300 - 2400));
    drain("stalled word");
    check("refused", {14'h0, seen_refuse}, 15'h1);
  endtask : stall_test

  // slow isolation of the data pins and back
  task automatic drive_enable_test();
    output_drive_enable_n = 1'b1;
    repeat (8) @(negedge mclk);
    check("drive off", {14'h0, data_oe}, 15'h0);
    check("pins", {3'h0, data_bus}, {3'h0, 12'hZZZ});
    output_drive_enable_n = 1'b0;
    repeat (8) @(negedge mclk);
    check("drive on", {14'h0, data_oe}, 15'h1);
  endtask : drive_enable_test

  // reset, then scenarios
  initial begin
    reset_n               = 1'b0;
    sample_valid          = 1'b0;
    sample_raw            = 14'h0000;
    format_select         = 1'b0;
    output_drive_enable_n = 1'b0;
    hold_off              = 1'b0;
    seen_refuse           = 1'b0;
    fail_count            = 0;
    n_compared            = 0;
    cycles                = 0;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    drive_enable_test();
    coding_table(1'b0);
    coding_table(1'b1);
    stall_test();
    report_and_stop();
  end
endmodule : testbench
